// [verilog/rssd_datapath.sv]
// Purpose: Execution datapath for rotates, subtracts, skips, set and swap
// Assumes: Operands arrive with op_valid; flags and accumulator live here
// Notes:   Memory results leave on mem_we/mem_wdata for the core to store
`timescale 1ns/1ps
module rssd_datapath
   import rssd_pkg::*;
(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    srst,
   // Instruction request from decode
   input  wire logic                    op_valid,
   input  wire rssd_pkg::rssd_op_t      op_sel,
   input  wire logic [rssd_pkg::W-1:0]  mem_rdata,
   input  wire logic [rssd_pkg::W-1:0]  imm_data,
   input  wire logic [rssd_pkg::BSEL_W-1:0] bit_sel,
   // Memory write-back
   output logic                         mem_we,
   output logic [rssd_pkg::W-1:0]       mem_wdata,
   // Architectural state
   output logic [rssd_pkg::W-1:0]       acc,
   output logic                         carry_flag,
   output logic                         zero_flag,
   output logic                         signed_wrap_flag,
   output logic                         half_carry_flag,
   // Sequencing toward the fetch logic
   output logic                         skip_next,
   output logic                         busy
);
   import rssd_pkg::*;

   typedef struct packed {
      rssd_state_t     state;
      logic [W-1:0]    acc;
      logic            c;
      logic            z;
      logic            ov;
      logic            ac;
      logic            we;
      logic [W-1:0]    wdata;
      logic            skip;
   } rssd_regs_t;

   rssd_regs_t cur;
   rssd_regs_t next_cur;

   // Shared adder: acc + ~operand + carry-in, split at bit 3 for half carry
   logic [W-1:0]   sub_opnd;
   logic           sub_cin;
   logic [NIB:0]   lo_sum;
   logic [NIB:0]   hi_sum;
   logic [W-1:0]   sub_res;
   logic           sub_ov;
   logic [W-1:0]   dec_res;
   logic [W-1:0]   inc_res;
   logic [W-1:0]   rot_l_c;
   logic [W-1:0]   rot_r;
   logic [W-1:0]   rot_r_c;
   logic [W-1:0]   swapped;
   logic [W-1:0]   bit_mask;

   always_comb begin
      sub_opnd = (op_sel == OP_SUB_IMM) ? ~imm_data : ~mem_rdata;
      sub_cin  = (op_sel == OP_SBB_ACC || op_sel == OP_SBB_MEM) ? cur.c : 1'b1;
      lo_sum   = {1'b0, cur.acc[NIB-1:0]} + {1'b0, sub_opnd[NIB-1:0]}
                 + {{NIB{1'b0}}, sub_cin};
      hi_sum   = {1'b0, cur.acc[W-1:NIB]} + {1'b0, sub_opnd[W-1:NIB]}
                 + {{NIB{1'b0}}, lo_sum[NIB]};
      sub_res  = {hi_sum[NIB-1:0], lo_sum[NIB-1:0]};
      sub_ov   = (cur.acc[MSB] == sub_opnd[MSB]) && (sub_res[MSB] != cur.acc[MSB]);
   end

   // Rotate, step, swap and mask helpers
   always_comb begin
      rot_l_c  = {mem_rdata[W-2:0], cur.c};
      rot_r    = {mem_rdata[0], mem_rdata[W-1:1]};
      rot_r_c  = {cur.c, mem_rdata[W-1:1]};
      swapped  = {mem_rdata[NIB-1:0], mem_rdata[W-1:NIB]};
      dec_res  = mem_rdata - ONE_BYTE;
      inc_res  = mem_rdata + ONE_BYTE;
      bit_mask = ONE_BYTE << bit_sel;
   end

   // Next-state: one op per cycle; a skip inserts one dummy cycle
   always_comb begin
      next_cur      = cur;
      next_cur.we   = 1'b0;
      next_cur.skip = 1'b0;
      if (srst) begin
         next_cur.state = ST_EXEC;
         next_cur.acc   = ZERO_BYTE;
         next_cur.c     = 1'b0;
         next_cur.z     = 1'b0;
         next_cur.ov    = 1'b0;
         next_cur.ac    = 1'b0;
         next_cur.wdata = ZERO_BYTE;
      end else begin
         case (cur.state)
            ST_DUMMY: begin
               // Prefetched word discarded; requests here are ignored
               next_cur.state = ST_EXEC;
            end
            ST_EXEC: begin
               if (op_valid) begin
                  case (op_sel)
                     OP_RLC_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = rot_l_c;
                        next_cur.c = mem_rdata[MSB];
                     end
                     OP_RLC_ACC: begin
                        next_cur.acc = rot_l_c;
                        next_cur.c = mem_rdata[MSB];
                     end
                     OP_RR_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = rot_r;
                     end
                     OP_RR_ACC: next_cur.acc = rot_r;
                     OP_RRC_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = rot_r_c;
                        next_cur.c = mem_rdata[0];
                     end
                     OP_RRC_ACC: begin
                        next_cur.acc = rot_r_c;
                        next_cur.c = mem_rdata[0];
                     end
                     OP_SBB_ACC, OP_SUB_ACC, OP_SUB_IMM: begin
                        next_cur.acc = sub_res;
                        next_cur.c = hi_sum[NIB];
                        next_cur.ac = lo_sum[NIB];
                        next_cur.ov = sub_ov;
                        next_cur.z = (sub_res == ZERO_BYTE);
                     end
                     OP_SBB_MEM, OP_SUB_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = sub_res;
                        next_cur.c = hi_sum[NIB];
                        next_cur.ac = lo_sum[NIB];
                        next_cur.ov = sub_ov;
                        next_cur.z = (sub_res == ZERO_BYTE);
                     end
                     OP_DSZ_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = dec_res;
                        next_cur.skip = (dec_res == ZERO_BYTE);
                     end
                     OP_DSZ_ACC: begin
                        next_cur.acc = dec_res;
                        next_cur.skip = (dec_res == ZERO_BYTE);
                     end
                     OP_ISZ_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = inc_res;
                        next_cur.skip = (inc_res == ZERO_BYTE);
                     end
                     OP_ISZ_ACC: begin
                        next_cur.acc = inc_res;
                        next_cur.skip = (inc_res == ZERO_BYTE);
                     end
                     OP_BTS_NZ: next_cur.skip = |(mem_rdata & bit_mask);
                     OP_SET_BYTE: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = ALL_ONES;
                     end
                     OP_SET_BIT: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = mem_rdata | bit_mask;
                     end
                     OP_SWAP_MEM: begin
                        next_cur.we = 1'b1;
                        next_cur.wdata = swapped;
                     end
                     OP_SWAP_ACC: next_cur.acc = swapped;
                     default: next_cur.we = 1'b0;
                  endcase
                  if (next_cur.skip) begin
                     next_cur.state = ST_DUMMY;
                  end
               end
            end
            default: next_cur.state = ST_EXEC;
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      cur <= next_cur;
   end

   // Outputs straight from flip-flops; skip pulse lines up with dummy cycle
   assign mem_we           = cur.we;
   assign mem_wdata        = cur.wdata;
   assign acc              = cur.acc;
   assign carry_flag       = cur.c;
   assign zero_flag        = cur.z;
   assign signed_wrap_flag = cur.ov;
   assign half_carry_flag  = cur.ac;
   assign skip_next        = cur.skip;
   assign busy             = (cur.state == ST_DUMMY);

   // Checks
   skip_dummy_a: assert property (@(posedge mclk) disable iff (srst)
      skip_next |-> busy ##1 !busy)
      else $error("skip without one dummy cycle");
   dummy_len_a: assert property (@(posedge mclk) disable iff (srst)
      busy |-> skip_next && !$past(busy))
      else $error("dummy cycle not caused by skip");
   rlc_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RLC_MEM) |=>
      mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)}
      && carry_flag == $past(mem_rdata[7]))
      else $error("left rotate through carry wrong");
   rr_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RR_ACC) |=>
      !mem_we && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
      && $stable(carry_flag))
      else $error("right rotate to acc wrong");
   sub_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SUB_ACC) |=>
      acc == 8'($past(acc) - $past(mem_rdata))
      && carry_flag == ($past(acc) >= $past(mem_rdata)))
      else $error("subtract result or carry wrong");
   sub_zero_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SUB_IMM) |=>
      zero_flag == (acc == 8'h00))
      else $error("zero flag mismatch");
   isz_skip_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_ISZ_MEM && mem_rdata == 8'hff) |=>
      skip_next && busy && mem_we && mem_wdata == 8'h00 ##1 !busy)
      else $error("increment wrap did not skip");
   set_byte_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SET_BYTE) |=>
      mem_we && mem_wdata == 8'hff && $stable(zero_flag))
      else $error("byte set wrong");
   swap_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SWAP_ACC) |=>
      !mem_we && acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
      else $error("swap to acc wrong");

   // Per-operation results, written from plain arithmetic rather than the adder
   // Subtracts are checked as a minus b minus borrow, a different route to the sum
   rlc_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RLC_ACC) |=>
      !mem_we && acc == {$past(mem_rdata[6:0]), $past(carry_flag)}
      && carry_flag == $past(mem_rdata[7]))
      else $error("left rotate to acc wrong");
   rr_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RR_MEM) |=>
      mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
      && $stable(carry_flag) && $stable(zero_flag) && $stable(acc))
      else $error("right rotate to memory wrong");
   rrc_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RRC_MEM) |=>
      mem_we && mem_wdata == {$past(carry_flag), $past(mem_rdata[7:1])}
      && carry_flag == $past(mem_rdata[0]))
      else $error("right rotate through carry wrong");
   rrc_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_RRC_ACC) |=>
      !mem_we && acc == {$past(carry_flag), $past(mem_rdata[7:1])}
      && carry_flag == $past(mem_rdata[0]))
      else $error("right rotate carry to acc wrong");
   sbb_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SBB_ACC) |=>
      !mem_we && acc == 8'($past(acc) - $past(mem_rdata) - {7'h00, !$past(carry_flag)})
      && zero_flag == (acc == 8'h00))
      else $error("subtract with borrow to acc wrong");
   sbb_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SBB_MEM) |=>
      mem_we && mem_wdata == 8'($past(acc) - $past(mem_rdata) - {7'h00, !$past(carry_flag)})
      && zero_flag == (mem_wdata == 8'h00) && $stable(acc))
      else $error("subtract with borrow to memory wrong");
   sub_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SUB_MEM) |=>
      mem_we && mem_wdata == 8'($past(acc) - $past(mem_rdata))
      && carry_flag == ($past(acc) >= $past(mem_rdata)) && $stable(acc))
      else $error("subtract to memory wrong");
   sub_imm_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SUB_IMM) |=>
      acc == 8'($past(acc) - $past(imm_data))
      && carry_flag == ($past(acc) >= $past(imm_data))
      && half_carry_flag == ($past(acc[3:0]) >= $past(imm_data[3:0])))
      else $error("subtract immediate wrong");
   sub_ov_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SUB_ACC) |=>
      signed_wrap_flag == (($past(acc[7]) != $past(mem_rdata[7]))
      && (acc[7] != $past(acc[7]))))
      else $error("signed overflow flag wrong");
   dsz_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_DSZ_MEM) |=>
      mem_we && mem_wdata == 8'($past(mem_rdata) - 8'h01)
      && skip_next == ($past(mem_rdata) == 8'h01) && $stable(carry_flag))
      else $error("decrement skip to memory wrong");
   dsz_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_DSZ_ACC) |=>
      !mem_we && acc == 8'($past(mem_rdata) - 8'h01)
      && skip_next == ($past(mem_rdata) == 8'h01) && $stable(zero_flag))
      else $error("decrement skip to acc wrong");
   isz_acc_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_ISZ_ACC) |=>
      !mem_we && acc == 8'($past(mem_rdata) + 8'h01)
      && skip_next == ($past(mem_rdata) == 8'hff) && $stable(carry_flag))
      else $error("increment skip to acc wrong");
   bts_skip_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_BTS_NZ) |=>
      !mem_we && skip_next == $past(mem_rdata[bit_sel]) && $stable(acc))
      else $error("bit test skip wrong");
   set_bit_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SET_BIT) |=>
      mem_we && mem_wdata[$past(bit_sel)]
      && (mem_wdata | (8'h01 << $past(bit_sel))) == ($past(mem_rdata) | (8'h01 << $past(bit_sel))))
      else $error("bit set wrong");
   swap_mem_a: assert property (@(posedge mclk) disable iff (srst)
      (op_valid && !busy && op_sel == OP_SWAP_MEM) |=>
      mem_we && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
      && $stable(acc) && $stable(carry_flag))
      else $error("swap in place wrong");
   // A request offered in the dummy cycle must leave no trace
   busy_ignore_a: assert property (@(posedge mclk) disable iff (srst)
      busy |=> !mem_we && !skip_next && $stable(acc) && $stable(carry_flag))
      else $error("request taken during dummy cycle");
endmodule

// [include/rssd_pkg.sv]
// Purpose: Shared constants for the rotate/subtract/skip/swap datapath
// Assumes: 8-bit data path, one core clock
// Notes:   Operation codes are binary-encoded values of the 5-bit op select port
package rssd_pkg;
   localparam int W = 8;
   localparam int MSB = 7;
   localparam int NIB = 4;
   localparam int BSEL_W = 3;
   // Operation select codes
   typedef enum logic [4:0] {
      OP_NONE        = 5'h00,
      OP_RLC_MEM     = 5'h01,
      OP_RLC_ACC     = 5'h02,
      OP_RR_MEM      = 5'h03,
      OP_RR_ACC      = 5'h04,
      OP_RRC_MEM     = 5'h05,
      OP_RRC_ACC     = 5'h06,
      OP_SBB_ACC     = 5'h07,
      OP_SBB_MEM     = 5'h08,
      OP_SUB_ACC     = 5'h09,
      OP_SUB_MEM     = 5'h0a,
      OP_SUB_IMM     = 5'h0b,
      OP_DSZ_MEM     = 5'h0c,
      OP_DSZ_ACC     = 5'h0d,
      OP_ISZ_MEM     = 5'h0e,
      OP_ISZ_ACC     = 5'h0f,
      OP_BTS_NZ      = 5'h10,
      OP_SET_BYTE    = 5'h11,
      OP_SET_BIT     = 5'h12,
      OP_SWAP_MEM    = 5'h13,
      OP_SWAP_ACC    = 5'h14
   } rssd_op_t;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Skip adds one dummy cycle: 2 cycles total instead of 1
   localparam int SKIP_CYCLES = 2;
   localparam int BASE_CYCLES = 1;
   // Execution state one-hot codes
   typedef enum logic [1:0] {
      ST_EXEC  = 2'h1,
      ST_DUMMY = 2'h2
   } rssd_state_t;
endpackage

// [test/rssd_fetch_model.sv]
// Purpose: Fetch-side partner that drops the prefetched word on a skip
// Assumes: One prefetch slot, refilled every cycle
// Notes:   Counts dropped words so the bench can match them to skips
`timescale 1ns/1ps
module rssd_fetch_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic srst,
   // Sequencing from the datapath
   input  wire logic skip_next,
   input  wire logic busy,
   // Observation
   output int        dropped
);
   // drop prefetch
   // A skip without the dummy cycle would lose the refetch, so both needed
   always_ff @(posedge mclk) begin
      if (srst) begin
         dropped <= 0;
      end else if (skip_next && busy) begin
         dropped <= dropped + 1;
      end
   end
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench for the rotate/subtract/skip/swap datapath
// Assumes: Requests change at the falling edge, results one cycle later
// Notes:   Corner cases first, then seeded random traffic with idle gaps
`timescale 1ns/1ps
module tb;
   import rssd_pkg::*;
   // Design inputs
   logic       mclk = 1'b0;
   logic       srst = 1'b1;
   logic       op_valid = 1'b0;
   rssd_op_t   op_sel = OP_NONE;
   logic [7:0] mem_rdata = 8'h00;
   logic [7:0] imm_data = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   // Design outputs
   logic       mem_we, skip_next, busy, carry_flag, zero_flag, signed_wrap_flag, half_carry_flag;
   logic [7:0] mem_wdata, acc;
   // Expected state
   logic [7:0] e_wd = 8'h00, e_acc = 8'h00;
   logic       e_we = 1'b0, e_skip = 1'b0, e_c = 1'b0, e_z = 1'b0, e_v = 1'b0, e_h = 1'b0;
   int         fail_count = 0, n_tests = 0, n_skip = 0, dropped;

   always #10 mclk = ~mclk;

   rssd_datapath i_dut (.mclk(mclk), .srst(srst), .op_valid(op_valid), .op_sel(op_sel),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag),
      .signed_wrap_flag(signed_wrap_flag), .half_carry_flag(half_carry_flag),
      .skip_next(skip_next), .busy(busy));

   rssd_fetch_model i_fetch (.mclk(mclk), .srst(srst), .skip_next(skip_next), .busy(busy),
      .dropped(dropped));

   // Result {overflow, half carry, carry, byte} of a + ~b + ci
   function automatic logic [10:0] sub_f(input logic [7:0] a, b, input logic ci);
      logic [8:0] r;
      logic [4:0] l;
      r = {1'b0, a} + {1'b0, ~b} + 9'(ci);
      l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
      return {(a[7] == ~b[7]) && (r[7] != a[7]), l[4], r[8], r[7:0]};
   endfunction

   // Expected outputs after one taken request
   task automatic predict(input rssd_op_t op, input logic [7:0] m, x, input logic [2:0] b);
      logic [10:0] s;
      e_we = 1'b0;
      e_skip = 1'b0;
      case (op)
         OP_RLC_MEM:  {e_c, e_wd, e_we} = {m, e_c, 1'b1};
         OP_RLC_ACC:  {e_c, e_acc} = {m, e_c};
         OP_RR_MEM:   {e_wd, e_we} = {m[0], m[7:1], 1'b1};
         OP_RR_ACC:   e_acc = {m[0], m[7:1]};
         OP_RRC_MEM:  {e_wd, e_c, e_we} = {e_c, m, 1'b1};
         OP_RRC_ACC:  {e_acc, e_c} = {e_c, m};
         OP_SBB_ACC, OP_SBB_MEM: s = sub_f(e_acc, m, e_c);
         OP_SUB_ACC, OP_SUB_MEM: s = sub_f(e_acc, m, 1'b1);
         OP_SUB_IMM:  s = sub_f(e_acc, x, 1'b1);
         OP_DSZ_MEM:  {e_wd, e_we, e_skip} = {m - 8'h01, 1'b1, m == 8'h01};
         OP_DSZ_ACC:  {e_acc, e_skip} = {m - 8'h01, m == 8'h01};
         OP_ISZ_MEM:  {e_wd, e_we, e_skip} = {m + 8'h01, 1'b1, m == 8'hff};
         OP_ISZ_ACC:  {e_acc, e_skip} = {m + 8'h01, m == 8'hff};
         OP_BTS_NZ:   e_skip = m[b];
         OP_SET_BYTE: {e_wd, e_we} = {ALL_ONES, 1'b1};
         OP_SET_BIT:  {e_wd, e_we} = {m | (8'h01 << b), 1'b1};
         OP_SWAP_MEM: {e_wd, e_we} = {m[3:0], m[7:4], 1'b1};
         OP_SWAP_ACC: e_acc = {m[3:0], m[7:4]};
         default:     e_we = 1'b0;
      endcase
      // Subtract family shares one flag update
      if (op >= OP_SBB_ACC && op <= OP_SUB_IMM) begin
         {e_v, e_h, e_c, e_z} = {s[10:8], s[7:0] == 8'h00};
         if (op == OP_SBB_MEM || op == OP_SUB_MEM) {e_wd, e_we} = {s[7:0], 1'b1};
         else e_acc = s[7:0];
      end
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk1(input string nm, input logic e, s);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic check_all();
      chk8("mem_wdata", e_wd, mem_wdata);
      chk8("acc", e_acc, acc);
      chk1("mem_we", e_we, mem_we);
      chk1("carry_flag", e_c, carry_flag);
      chk1("zero_flag", e_z, zero_flag);
      chk1("signed_wrap_flag", e_v, signed_wrap_flag);
      chk1("half_carry_flag", e_h, half_carry_flag);
      chk1("skip_next", e_skip, skip_next);
      chk1("busy", e_skip, busy);
   endtask

   // One request; after a skip a random request is offered and must be ignored
   task automatic do_op(input rssd_op_t op, input logic [7:0] m, x = 8'h00,
                        input logic [2:0] b = 3'h0, input logic v = 1'b1);
      op_valid = v;
      op_sel = op;
      mem_rdata = m;
      imm_data = x;
      bit_sel = b;
      if (v) predict(op, m, x, b);
      else {e_we, e_skip} = 2'b00;
      @(negedge mclk);
      check_all();
      if (e_skip) begin
         n_skip++;
         op_sel = rssd_op_t'($urandom_range(20, 0));
         mem_rdata = 8'($urandom);
         @(negedge mclk);
         {e_we, e_skip} = 2'b00;
         check_all();
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h13a8));
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      check_all();
      do_op(OP_SUB_IMM, 8'h00, 8'h00);
      do_op(OP_RLC_MEM, 8'h80);
      do_op(OP_RLC_ACC, 8'h7f);
      do_op(OP_RRC_MEM, 8'h01);
      do_op(OP_RRC_ACC, 8'h02);
      do_op(OP_RR_MEM, 8'h01);
      do_op(OP_RR_ACC, 8'h03);
      do_op(OP_SUB_ACC, 8'h01);
      do_op(OP_SUB_MEM, 8'h01);
      do_op(OP_SBB_ACC, 8'hff);
      do_op(OP_SBB_MEM, 8'h00);
      do_op(OP_DSZ_MEM, 8'h01);
      do_op(OP_DSZ_MEM, 8'h00);
      do_op(OP_DSZ_ACC, 8'h01);
      do_op(OP_ISZ_MEM, 8'hff);
      do_op(OP_ISZ_ACC, 8'hff);
      do_op(OP_ISZ_ACC, 8'h00);
      for (int i = 0; i < 8; i++) begin
         do_op(OP_BTS_NZ, 8'h01 << i, 8'h00, 3'(i));
         do_op(OP_BTS_NZ, ~(8'h01 << i), 8'h00, 3'(i));
         do_op(OP_SET_BIT, 8'h00, 8'h00, 3'(i));
      end
      do_op(OP_SET_BYTE, 8'h12);
      do_op(OP_SWAP_MEM, 8'h5a);
      do_op(OP_SWAP_ACC, 8'hc3);
      do_op(rssd_op_t'(5'h1f), 8'h55);
      $display("test corner done");
      // Random mix with idle cycles between requests
      repeat (600) begin
         do_op(rssd_op_t'($urandom_range(20, 0)), 8'($urandom), 8'($urandom),
               3'($urandom), 1'($urandom_range(3, 0) != 0));
      end
      op_valid = 1'b0;
      $display("test random done");
      chk8("dropped", 8'(n_skip), 8'(dropped));
      summarize();
   end

   // Watchdog: far beyond the longest expected run
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      summarize();
   end
endmodule
